// file: hw/wdcp_pkg.sv
// Purpose: Shared constants and types for the watchdog-clear, decrement and invert executor.
// Assumes: 14-bit instruction words, 8-bit data path, 128 data registers.
// Notes: Decrement and invert patterns are compared under OP_MASK; the watchdog-clear word is matched in full.
package wdcp_pkg;
  localparam int          INSN_W          = 14;
  localparam int          DATA_W          = 8;
  localparam int          ADDR_W          = 7;
  localparam int          WDT_W           = 8;
  localparam int          PRE_W           = 8;
  localparam int          DEST_BIT        = 7;
  localparam logic [13:0] WDCLR_WORD      = 14'h0064;
  localparam logic [13:0] OP_MASK         = 14'h3F00;
  localparam logic [13:0] DEC_PATTERN     = 14'h0300;
  localparam logic [13:0] INV_PATTERN     = 14'h0900;
  localparam logic [7:0]  DATA_RST        = 8'h00;
  localparam logic [7:0]  WDT_CLEAR_VAL   = 8'h00;
  localparam logic [7:0]  PRE_CLEAR_VAL   = 8'h00;

  typedef enum logic [1:0] {
    WDCP_OP_NONE  = 2'b00,
    WDCP_OP_WDCLR = 2'b01,
    WDCP_OP_DEC   = 2'b10,
    WDCP_OP_INV   = 2'b11
  } wdcp_op_t;

  typedef struct packed {
    wdcp_op_t          op;
    logic              dest_file;
    logic [ADDR_W-1:0] addr;
  } wdcp_dec_t;
endpackage : wdcp_pkg

// file: hw/wdcp_decode.sv
// Purpose: Combinational decoder for the three supported instruction words.
// Assumes: Instruction word is stable for the cycle in which it is valid.
// Notes: Unsupported words decode to no operation.
`timescale 1ns/1ns
`default_nettype none
module wdcp_decode (
  input  wire logic [13:0]         insn,
  input  wire logic                valid,
  output var wdcp_pkg::wdcp_dec_t  dec
);
  always_comb begin
    dec.op        = wdcp_pkg::WDCP_OP_NONE;
    dec.dest_file = insn[wdcp_pkg::DEST_BIT];
    dec.addr      = insn[6:0];
    if (valid) begin
      if (insn == wdcp_pkg::WDCLR_WORD) begin
        dec.op = wdcp_pkg::WDCP_OP_WDCLR;
      end else if ((insn & wdcp_pkg::OP_MASK) == wdcp_pkg::DEC_PATTERN) begin
        dec.op = wdcp_pkg::WDCP_OP_DEC;
      end else if ((insn & wdcp_pkg::OP_MASK) == wdcp_pkg::INV_PATTERN) begin
        dec.op = wdcp_pkg::WDCP_OP_INV;
      end
    end
  end
endmodule : wdcp_decode
`default_nettype wire

// file: hw/wdcp_core.sv
// Purpose: Executes watchdog clear, register decrement and register invert in one cycle each.
// Assumes: One instruction per clock on INSN with INSN_VALID; no software registers.
// Notes: Data registers, working register, zero flag and status flags live here.
`timescale 1ns/1ns
`default_nettype none
module wdcp_core #(
  parameter int DEPTH = 128
) (
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  input  wire logic [13:0] INSN,
  input  wire logic        INSN_VALID,
  input  wire logic        WDT_TICK,
  output logic [7:0]       WORK_REG,
  output logic             ZERO_FLAG,
  output logic             TIMEOUT_FLAG,
  output logic             POWERDOWN_FLAG,
  output logic [7:0]       WDT_COUNT,
  output logic [7:0]       WDT_PRESCALE,
  output logic             OP_DONE,
  input  wire logic [6:0]  PEEK_ADDR,
  output logic [7:0]       PEEK_DATA
);
  wdcp_pkg::wdcp_dec_t dec;
  logic [7:0] file_reg [DEPTH];
  logic [7:0] file_next [DEPTH];
  logic [7:0] work_reg, work_next;
  logic       zero_reg, zero_next;
  logic       to_reg, to_next;
  logic       pd_reg, pd_next;
  logic [7:0] wdt_reg, wdt_next;
  logic [7:0] pre_reg, pre_next;
  logic       done_reg, done_next;
  logic [7:0] peek_reg, peek_next;
  logic [7:0] src;
  logic [7:0] result;

  wdcp_decode u_decode (
    .insn  (INSN),
    .valid (INSN_VALID),
    .dec   (dec)
  );

  assign src = file_reg[dec.addr];

  always_comb begin
    result     = src;
    file_next  = file_reg;
    work_next  = work_reg;
    zero_next  = zero_reg;
    to_next    = to_reg;
    pd_next    = pd_reg;
    wdt_next   = wdt_reg;
    pre_next   = pre_reg;
    done_next  = 1'b0;
    peek_next  = file_reg[PEEK_ADDR];
    if (WDT_TICK) begin
      pre_next = pre_reg + 8'h01;
      if (pre_reg == 8'hFF) begin
        wdt_next = wdt_reg + 8'h01;
      end
    end
    case (dec.op)
      wdcp_pkg::WDCP_OP_WDCLR: begin
        wdt_next  = wdcp_pkg::WDT_CLEAR_VAL;
        pre_next  = wdcp_pkg::PRE_CLEAR_VAL;
        to_next   = 1'b1;
        pd_next   = 1'b1;
        done_next = 1'b1;
      end
      wdcp_pkg::WDCP_OP_DEC, wdcp_pkg::WDCP_OP_INV: begin
        if (dec.op == wdcp_pkg::WDCP_OP_DEC) begin
          result = src - 8'h01;
        end else begin
          result = ~src;
        end
        if (dec.dest_file) begin
          file_next[dec.addr] = result;
        end else begin
          work_next = result;
        end
        zero_next = (result == 8'h00);
        done_next = 1'b1;
      end
      default: begin
        done_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int i = 0; i < DEPTH; i++) begin
        file_reg[i] <= wdcp_pkg::DATA_RST;
      end
      work_reg <= wdcp_pkg::DATA_RST;
      zero_reg <= 1'b0;
      to_reg   <= 1'b1;
      pd_reg   <= 1'b1;
      wdt_reg  <= wdcp_pkg::WDT_CLEAR_VAL;
      pre_reg  <= wdcp_pkg::PRE_CLEAR_VAL;
      done_reg <= 1'b0;
      peek_reg <= wdcp_pkg::DATA_RST;
    end else begin
      file_reg <= file_next;
      work_reg <= work_next;
      zero_reg <= zero_next;
      to_reg   <= to_next;
      pd_reg   <= pd_next;
      wdt_reg  <= wdt_next;
      pre_reg  <= pre_next;
      done_reg <= done_next;
      peek_reg <= peek_next;
    end
  end

  assign WORK_REG       = work_reg;
  assign ZERO_FLAG      = zero_reg;
  assign TIMEOUT_FLAG   = to_reg;
  assign POWERDOWN_FLAG = pd_reg;
  assign WDT_COUNT      = wdt_reg;
  assign WDT_PRESCALE   = pre_reg;
  assign OP_DONE        = done_reg;
  assign PEEK_DATA      = peek_reg;
endmodule : wdcp_core
`default_nettype wire

// file: tb/wdcp_core_assertions.sv
// Purpose: Port assertions for wdcp_core.
// Assumes: One clock domain.
// Notes: Bound to every wdcp_core.
`timescale 1ns/1ns
`default_nettype none
module wdcp_chk (
  input wire logic        CLOCK,
  input wire logic        SYS_RST,
  input wire logic [13:0] INSN,
  input wire logic        INSN_VALID,
  input wire logic [7:0]  WORK_REG,
  input wire logic        ZERO_FLAG,
  input wire logic        TIMEOUT_FLAG,
  input wire logic        POWERDOWN_FLAG,
  input wire logic [7:0]  WDT_COUNT,
  input wire logic [7:0]  WDT_PRESCALE,
  input wire logic        OP_DONE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  wire logic clr = INSN_VALID && INSN == 14'h0064;
  wire logic dec = INSN_VALID && INSN[13:8] == 6'h03;
  wire logic inv = INSN_VALID && INSN[13:8] == 6'h09;
  wdclr_count_a: assert property (clr |=> WDT_COUNT == 8'h00) else $error("count kept");
  wdclr_side_a: assert property (clr |=> !WDT_PRESCALE && TIMEOUT_FLAG && POWERDOWN_FLAG && OP_DONE)
    else $error("clear effects wrong");
  dec_zero_a: assert property (dec && !INSN[7] |=> ZERO_FLAG == !WORK_REG) else $error("dec zero");
  dec_keep_a: assert property (dec && INSN[7] |=> $stable(WORK_REG) && OP_DONE) else $error("dec dest");
  inv_zero_a: assert property (inv && !INSN[7] |=> ZERO_FLAG == !WORK_REG) else $error("inv zero");
  inv_keep_a: assert property (inv && INSN[7] |=> $stable(WORK_REG)) else $error("inv dest");
  idle_quiet_a: assert property (!(clr || dec || inv) |=> !OP_DONE && $stable(WORK_REG)) else $error("idle");
  cover property (clr);
  cover property (dec ##1 inv);
  cover property (inv && INSN[7]);
endmodule : wdcp_chk
bind wdcp_core wdcp_chk u_chk (.*);
`default_nettype wire

// file: tb/wdcp_core_tb.sv
// Purpose: Self-checking bench for wdcp_core.
// Assumes: Inputs change on falling edges.
// Notes: Data registers are seen through the peek port.
`timescale 1ns/1ns
`default_nettype none
module wdcp_core_tb;
  logic        clock = 0, sys_rst = 1, valid = 0, tick = 0, zf, tf, pf, done;
  logic [13:0] insn = 14'h0000;
  logic [6:0]  peek = 7'h7F;
  logic [7:0]  wr, cnt, pre, pd;
  int          errors = 0, samples_checked = 0;
  always #4 clock = ~clock;
  wdcp_core dut (.CLOCK(clock), .SYS_RST(sys_rst), .INSN(insn), .INSN_VALID(valid), .WDT_TICK(tick),
    .WORK_REG(wr), .ZERO_FLAG(zf), .TIMEOUT_FLAG(tf), .POWERDOWN_FLAG(pf), .WDT_COUNT(cnt),
    .WDT_PRESCALE(pre), .OP_DONE(done), .PEEK_ADDR(peek), .PEEK_DATA(pd));
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic step(input logic [13:0] w, input logic [7:0] ew, input logic ez, input logic [7:0] ep);
    insn = w;
    valid = 1;
    @(negedge clock);
    cmp("work", ew, wr);
    cmp("zero", {7'h00, ez}, {7'h00, zf});
    cmp("peek", ep, pd);
  endtask : step
  task automatic t_wdclr;
    tick = 1;
    repeat (300) @(negedge clock);
    cmp("count", 8'h01, cnt);
    cmp("prescale", 8'h2C, pre);
    step(14'h0064, 8'h00, 1'b0, 8'h00);
    cmp("count", 8'h00, cnt);
    cmp("prescale", 8'h00, pre);
    cmp("flags", 8'h07, {5'h00, tf, pf, done});
    tick = 0;
  endtask : t_wdclr
  task automatic t_regs;
    step(14'h09FF, 8'h00, 1'b0, 8'h00);
    step(14'h03FF, 8'h00, 1'b0, 8'hFF);
    step(14'h09FF, 8'h00, 1'b0, 8'hFE);
    step(14'h037F, 8'h00, 1'b1, 8'h01);
    step(14'h097F, 8'hFE, 1'b0, 8'h01);
    step(14'h0000, 8'hFE, 1'b0, 8'h01);
    cmp("done", 8'h00, {7'h00, done});
    peek = 7'h00;
    step(14'h0980, 8'hFE, 1'b0, 8'h00);
    step(14'h0000, 8'hFE, 1'b0, 8'hFF);
    valid = 0;
  endtask : t_regs
  task automatic final_report;
    if (errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  initial begin
    repeat (3) @(negedge clock);
    sys_rst = 0;
    t_wdclr;
    t_regs;
    final_report;
  end
endmodule : wdcp_core_tb
`default_nettype wire
